//--- rtl/phy_ctl_consts.vh
`ifndef PHY_CTL_CONSTS_VH
`define PHY_CTL_CONSTS_VH

// Register offsets on the switch register port
`define OFS_P1_CTL_A 8'h1C
`define OFS_P2_CTL_A 8'h2C
`define OFS_P3_CTL_A 8'h3C
`define OFS_P1_CTL_B 8'h1D
`define OFS_P2_CTL_B 8'h2D
`define OFS_P3_CTL_B 8'h3D

// First control register fields
`define CA_AN_EN     7
`define CA_SPD100    6
`define CA_FDPX      5
`define CA_ADV_PAUSE 4
`define CA_ADV_100F  3
`define CA_ADV_100H  2
`define CA_ADV_10F   1
`define CA_ADV_10H   0

// Second control register fields
`define CB_LED_OFF   7
`define CB_TXDIS     6
`define CB_RESTART   5
`define CB_FEF_DIS   4
`define CB_PWRDN     3
`define CB_MDIX_DIS  2
`define CB_FORCE_MDI 1

// Reset values, write mask and idle read data
`define CTL_A_RST    8'hFF
`define CTL_B_RST    8'h00
`define CTL_B_MASK   8'hFE
`define RDATA_IDLE   8'h00

// Count at which straps are taken, on the fifth edge after reset release; the synchroniser
// output first settles on the fourth edge, so the load waits one more
`define STRAP_LOAD_CNT 3'h4

`endif

//--- rtl/strap_sync3.v
`timescale 1ns/10ps
`default_nettype none

module strap_sync3 (
  input  wire clk_i,
  input  wire resetn_i,
  input  wire d_i,
  output reg  q_o
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Stage one feeds stage two only; a change counts once two and three agree
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      q_o  <= 1'b1;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_o <= s3_r;
      end
    end
  end

endmodule // strap_sync3

`default_nettype wire

//--- rtl/phy_port_link_control_bits.v
`timescale 1ns/10ps
`default_nettype none
`include "phy_ctl_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module phy_port_link_control_bits (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       port1_duplex_strap_i,
  input  wire       port1_an_fail_i,
  input  wire       port1_an_full_duplex_i,
  input  wire       port1_mdix_status_i,
  input  wire       port1_led_one_i,
  input  wire       port1_led_zero_i,
  input  wire       port2_duplex_strap_i,
  input  wire       port2_an_fail_i,
  input  wire       port2_an_full_duplex_i,
  input  wire       port2_mdix_status_i,
  input  wire       port2_led_one_i,
  input  wire       port2_led_zero_i,
  output wire       port1_an_enable_o,
  output wire       port1_speed100_o,
  output wire       port1_full_duplex_o,
  output wire [4:0] port1_adv_o,
  output wire       port1_indicator_pin_one_o,
  output wire       port1_indicator_pin_zero_o,
  output wire       port1_tx_disable_o,
  output wire       port1_an_restart_o,
  output wire       port1_fef_disable_o,
  output wire       port1_power_down_o,
  output wire       port1_auto_mdix_en_o,
  output wire       port1_tx_on_receive_named_pair_o,
  output wire       port2_an_enable_o,
  output wire       port2_speed100_o,
  output wire       port2_full_duplex_o,
  output wire [4:0] port2_adv_o,
  output wire       port2_indicator_pin_one_o,
  output wire       port2_indicator_pin_zero_o,
  output wire       port2_tx_disable_o,
  output wire       port2_an_restart_o,
  output wire       port2_fef_disable_o,
  output wire       port2_power_down_o,
  output wire       port2_auto_mdix_en_o,
  output wire       port2_tx_on_receive_named_pair_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam NPORT = 2;

  reg  [7:0] ctl_a_r [0:NPORT-1];
  reg  [7:0] ctl_b_r [0:NPORT-1];
  reg  [2:0] strap_cnt_r;
  reg        strap_done_r;
  reg  [7:0] rdata_nxt;

  reg  [NPORT-1:0] full_dpx_r;
  reg  [NPORT-1:0] led_one_r;
  reg  [NPORT-1:0] led_zero_r;
  reg  [NPORT-1:0] restart_r;
  reg  [NPORT-1:0] tx_rx_pair_r;

  wire [NPORT-1:0] strap_sync;
  wire [NPORT-1:0] an_fail;
  wire [NPORT-1:0] an_full;
  wire [NPORT-1:0] mdix_stat;
  wire [NPORT-1:0] led_one_raw;
  wire [NPORT-1:0] led_zero_raw;

  integer p;
  integer rp;
  integer cp;

  assign an_fail      = {port2_an_fail_i, port1_an_fail_i};
  assign an_full      = {port2_an_full_duplex_i, port1_an_full_duplex_i};
  assign mdix_stat    = {port2_mdix_status_i, port1_mdix_status_i};
  assign led_one_raw  = {port2_led_one_i, port1_led_one_i};
  assign led_zero_raw = {port2_led_zero_i, port1_led_zero_i};

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function [7:0] ofs_a;
    input integer idx;
    begin
      ofs_a = (idx == 0) ? `OFS_P1_CTL_A : `OFS_P2_CTL_A;
    end
  endfunction

  function [7:0] ofs_b;
    input integer idx;
    begin
      ofs_b = (idx == 0) ? `OFS_P1_CTL_B : `OFS_P2_CTL_B;
    end
  endfunction

  // Negotiated result unless negotiation is off or gave up
  function resolve_dpx;
    input [7:0] ca;
    input       fail;
    input       neg_full;
    begin
      if (!ca[`CA_AN_EN] || fail) begin
        resolve_dpx = ca[`CA_FDPX];
      end else begin
        resolve_dpx = neg_full;
      end
    end
  endfunction

  // High means transmit on the receive-named pair (MDI)
  function resolve_pair;
    input [7:0] cb;
    input       stat;
    begin
      if (cb[`CB_MDIX_DIS]) begin
        resolve_pair = cb[`CB_FORCE_MDI];
      end else begin
        resolve_pair = stat;
      end
    end
  endfunction

  function [4:0] adv_bits;
    input [7:0] ca;
    begin
      adv_bits = ca[4:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture

  strap_sync3 u_strap1 (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (port1_duplex_strap_i),
    .q_o      (strap_sync[0])
  );

  strap_sync3 u_strap2 (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (port2_duplex_strap_i),
    .q_o      (strap_sync[1])
  );

  // The synchroniser needs a few edges before its output means anything,
  // so the strap is taken a fixed count after release, not at reset.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_cnt_r  <= 3'h0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == `STRAP_LOAD_CNT) begin
        strap_done_r <= 1'b1;
      end else begin
        strap_cnt_r <= strap_cnt_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (p = 0; p < NPORT; p = p + 1) begin
        ctl_a_r[p] <= `CTL_A_RST;
        ctl_b_r[p] <= `CTL_B_RST;
      end
    end else begin
      for (p = 0; p < NPORT; p = p + 1) begin
        if (!strap_done_r && strap_cnt_r == `STRAP_LOAD_CNT) begin
          ctl_a_r[p][`CA_FDPX] <= strap_sync[p];
        end else if (wr_i && addr_i == ofs_a(p)) begin
          ctl_a_r[p] <= wdata_i;
        end
        // Loopback bit is not carried here and reads as zero
        if (wr_i && addr_i == ofs_b(p)) begin
          ctl_b_r[p] <= wdata_i & `CTL_B_MASK;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads

  always @* begin
    rdata_nxt = `RDATA_IDLE;
    for (rp = 0; rp < NPORT; rp = rp + 1) begin
      if (addr_i == ofs_a(rp)) begin
        rdata_nxt = ctl_a_r[rp];
      end
      if (addr_i == ofs_b(rp)) begin
        rdata_nxt = ctl_b_r[rp];
      end
    end
  end

  // Data stands only in the cycle after the read; port 3 offsets read zero
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `RDATA_IDLE;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= `RDATA_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port controls

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      full_dpx_r   <= {NPORT{1'b0}};
      led_one_r    <= {NPORT{1'b1}};
      led_zero_r   <= {NPORT{1'b1}};
      restart_r    <= {NPORT{1'b0}};
      tx_rx_pair_r <= {NPORT{1'b0}};
    end else begin
      for (cp = 0; cp < NPORT; cp = cp + 1) begin
        full_dpx_r[cp]   <= resolve_dpx(ctl_a_r[cp], an_fail[cp], an_full[cp]);
        // Indicators are active low, so high means dark
        led_one_r[cp]    <= led_one_raw[cp] | ctl_b_r[cp][`CB_LED_OFF];
        led_zero_r[cp]   <= led_zero_raw[cp] | ctl_b_r[cp][`CB_LED_OFF];
        // A written one gives one pulse; the stored bit alone never retriggers
        restart_r[cp]    <= wr_i && addr_i == ofs_b(cp) && wdata_i[`CB_RESTART];
        tx_rx_pair_r[cp] <= resolve_pair(ctl_b_r[cp], mdix_stat[cp]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output mapping

  assign port1_an_enable_o                = ctl_a_r[0][`CA_AN_EN];
  assign port1_speed100_o                 = ctl_a_r[0][`CA_SPD100];
  assign port1_full_duplex_o              = full_dpx_r[0];
  assign port1_adv_o                      = adv_bits(ctl_a_r[0]);
  assign port1_indicator_pin_one_o        = led_one_r[0];
  assign port1_indicator_pin_zero_o       = led_zero_r[0];
  assign port1_tx_disable_o               = ctl_b_r[0][`CB_TXDIS];
  assign port1_an_restart_o               = restart_r[0];
  assign port1_fef_disable_o              = ctl_b_r[0][`CB_FEF_DIS];
  assign port1_power_down_o               = ctl_b_r[0][`CB_PWRDN];
  assign port1_auto_mdix_en_o             = ~ctl_b_r[0][`CB_MDIX_DIS];
  assign port1_tx_on_receive_named_pair_o = tx_rx_pair_r[0];

  assign port2_an_enable_o                = ctl_a_r[1][`CA_AN_EN];
  assign port2_speed100_o                 = ctl_a_r[1][`CA_SPD100];
  assign port2_full_duplex_o              = full_dpx_r[1];
  assign port2_adv_o                      = adv_bits(ctl_a_r[1]);
  assign port2_indicator_pin_one_o        = led_one_r[1];
  assign port2_indicator_pin_zero_o       = led_zero_r[1];
  assign port2_tx_disable_o               = ctl_b_r[1][`CB_TXDIS];
  assign port2_an_restart_o               = restart_r[1];
  assign port2_fef_disable_o              = ctl_b_r[1][`CB_FEF_DIS];
  assign port2_power_down_o               = ctl_b_r[1][`CB_PWRDN];
  assign port2_auto_mdix_en_o             = ~ctl_b_r[1][`CB_MDIX_DIS];
  assign port2_tx_on_receive_named_pair_o = tx_rx_pair_r[1];

endmodule // phy_port_link_control_bits

`default_nettype wire

//--- dv/phy_port_link_control_bits_sva.sv
`timescale 1ns/10ps
`default_nettype none
module link_ctl_chk (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       port1_an_fail_i,
  input wire logic       port1_an_full_duplex_i,
  input wire logic       port1_mdix_status_i,
  input wire logic       port1_an_enable_o,
  input wire logic       port1_full_duplex_o,
  input wire logic [4:0] port1_adv_o,
  input wire logic       port1_indicator_pin_one_o,
  input wire logic       port1_indicator_pin_zero_o,
  input wire logic       port1_tx_disable_o,
  input wire logic       port1_an_restart_o,
  input wire logic       port1_auto_mdix_en_o,
  input wire logic       port1_tx_on_receive_named_pair_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire wa = wr_i && addr_i == 8'h1C;
  wire wb = wr_i && addr_i == 8'h1D;
  a_led_off_high: assert property (
    wb && wdata_i[7] ##1 !wb |=> port1_indicator_pin_one_o && port1_indicator_pin_zero_o)
    else $error("indicators not blanked");
  a_restart_pulse: assert property (wb && wdata_i[5] |=> port1_an_restart_o)
    else $error("restart missing");
  a_restart_once: assert property (port1_an_restart_o |-> $past(wb && wdata_i[5]))
    else $error("restart without write");
  a_txdis_follow: assert property (wb |=> port1_tx_disable_o == $past(wdata_i[6]))
    else $error("tx disable wrong");
  a_mdix_auto: assert property (wb |=> port1_auto_mdix_en_o != $past(wdata_i[2]))
    else $error("crossover enable wrong");
  a_adv_follow: assert property (wa |=> port1_adv_o == $past(wdata_i[4:0]))
    else $error("advertised bits wrong");
  a_pair_auto: assert property (
    port1_auto_mdix_en_o |=> port1_tx_on_receive_named_pair_o == $past(port1_mdix_status_i))
    else $error("pair not from crossover result");
  a_duplex_neg: assert property (
    port1_an_enable_o && !port1_an_fail_i |=> port1_full_duplex_o == $past(port1_an_full_duplex_i))
    else $error("negotiated duplex wrong");
  c_restart: cover property (port1_an_restart_o);
  c_led_off: cover property (wb && wdata_i[7]);
  c_forced: cover property (!port1_auto_mdix_en_o && port1_tx_on_receive_named_pair_o);
endmodule // link_ctl_chk
`default_nettype wire

//--- dv/link_partner_model.sv
`timescale 1ns/10ps
`default_nettype none
module link_partner_model (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic restart_i,
  input  wire logic fail_mode_i,
  input  wire logic full_cap_i,
  input  wire logic mdi_i,
  output var  logic an_fail_o,
  output var  logic an_full_o,
  output var  logic mdi_o
);
  // Results move only on a restart, as a real partner renegotiates
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      an_fail_o <= 1'b0;
      an_full_o <= 1'b0;
      mdi_o     <= 1'b0;
    end else if (restart_i) begin
      an_fail_o <= fail_mode_i;
      an_full_o <= full_cap_i & ~fail_mode_i;
      mdi_o     <= mdi_i;
    end
  end
endmodule // link_partner_model
`default_nettype wire

//--- dv/phy_port_link_control_bits_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module phy_port_link_control_bits_tb_top;
  logic       clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       fm = 1'b0;
  logic       mi = 1'b0;
  logic [7:0] rcnt = 8'h00;
  logic [7:0] rcnt2 = 8'h00;
  logic [7:0] c0;
  logic [7:0] d;
  int         tests_run = 0;
  int         bad_count = 0;
  wire  [7:0] rdata_o;
  wire  [4:0] adv1;
  wire        pf, pn, pm, fd1, l1a, l1b, tx1, rs1, fef1, pd1, mx1, pr1, l2a, l2b;
  wire  [4:0] adv2;
  wire        ae1, sp1, ae2, sp2, fd2, tx2, rs2, fef2, pd2, mx2, pr2;
  logic [7:0] tv [7] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h06, 8'h02};

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (rs1 === 1'b1) rcnt <= rcnt + 8'h01;
  always @(posedge clk_i) if (rs2 === 1'b1) rcnt2 <= rcnt2 + 8'h01;

  link_partner_model lp (.clk_i(clk_i), .resetn_i(resetn_i), .restart_i(rs1), .fail_mode_i(fm),
    .full_cap_i(1'b1), .mdi_i(mi), .an_fail_o(pf), .an_full_o(pn), .mdi_o(pm));

  phy_port_link_control_bits uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .port1_duplex_strap_i(1'b1), .port1_an_fail_i(pf), .port1_an_full_duplex_i(pn),
    .port1_mdix_status_i(pm), .port1_led_one_i(1'b0), .port1_led_zero_i(1'b0),
    .port2_duplex_strap_i(1'b0), .port2_an_fail_i(pf), .port2_an_full_duplex_i(pn),
    .port2_mdix_status_i(pm), .port2_led_one_i(fm), .port2_led_zero_i(mi),
    .port1_an_enable_o(ae1), .port1_speed100_o(sp1), .port1_full_duplex_o(fd1), .port1_adv_o(adv1),
    .port1_indicator_pin_one_o(l1a), .port1_indicator_pin_zero_o(l1b), .port1_tx_disable_o(tx1),
    .port1_an_restart_o(rs1), .port1_fef_disable_o(fef1), .port1_power_down_o(pd1),
    .port1_auto_mdix_en_o(mx1), .port1_tx_on_receive_named_pair_o(pr1),
    .port2_an_enable_o(ae2), .port2_speed100_o(sp2), .port2_full_duplex_o(fd2), .port2_adv_o(adv2),
    .port2_indicator_pin_one_o(l2a), .port2_indicator_pin_zero_o(l2b), .port2_tx_disable_o(tx2),
    .port2_an_restart_o(rs2), .port2_fef_disable_o(fef2), .port2_power_down_o(pd2),
    .port2_auto_mdix_en_o(mx2), .port2_tx_on_receive_named_pair_o(pr2));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask

  // Settles three edges so registered and partner outputs have all landed
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(n, rdata_o, e);
  endtask

  task complete_run;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    bad_count++;
    complete_run;
  end

  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(8'h1C, 8'hFF, "ctl_a1");
    rd(8'h2C, 8'hDF, "ctl_a2");
    rd(8'h1D, 8'h00, "ctl_b1");
    wr(8'h3D, 8'hFF);
    rd(8'h3D, 8'h00, "reserved");
    for (int i = 0; i < 5; i++) begin
      wr(8'h1C, 8'hC0 | (8'h01 << i));
      chk("adv", {3'h0, adv1}, 8'h01 << i);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      fm <= i[1];
      wr(8'h1D, 8'h20);
      wr(8'h1C, {i[2], 1'b0, i[0], 5'h1F});
      chk("duplex", {7'h0, fd1}, (i[2] && !i[1]) ? 8'h01 : {7'h0, i[0]});
      chk("an enable", {6'h0, ae1, sp1}, {6'h0, i[2], 1'b0});
    end
    c0 = rcnt;
    @(posedge clk_i);
    mi <= 1'b1;
    wr_i <= 1'b1;
    addr_i <= 8'h1D;
    wdata_i <= 8'h20;
    @(posedge clk_i);
    wdata_i <= 8'h24;
    @(posedge clk_i);
    wr_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("restarts", rcnt - c0, 8'h02);
    for (int k = 0; k < 7; k++) begin
      d = tv[k];
      wr(8'h1D, d);
      chk("ctl_b", {l1a & l1b, tx1, 1'b0, fef1, pd1, ~mx1, pr1, 1'b0},
          {d[7:3] & 5'h1B, d[2], d[2] ? d[1] : mi, 1'b0});
    end
    wr(8'h1D, 8'hFF);
    rd(8'h1D, 8'hFE, "ctl_b back");
    wr(8'h2C, 8'hBF);
    chk("ctl_a2 out", {ae2, sp2, fd2, adv2}, 8'hBF);
    // Raw indicators low so only the blanking bit can raise them
    @(posedge clk_i);
    fm <= 1'b0;
    mi <= 1'b0;
    wr(8'h2D, 8'h80);
    chk("led2", {6'h0, l2a, l2b}, 8'h03);
    c0 = rcnt2;
    wr(8'h2D, 8'hFE);
    chk("ctl_b2", {l2a & l2b, tx2, 1'b0, fef2, pd2, ~mx2, pr2, 1'b0},
        8'hDE);
    chk("restart2", rcnt2 - c0, 8'h01);
    rd(8'h2D, 8'hFE, "ctl_b2 back");
    wr(8'h2D, 8'h00);
    chk("ctl_b2 off", {l2a | l2b, tx2, 1'b0, fef2, pd2, ~mx2, pr2, 1'b0},
        8'h02);
    complete_run;
  end
endmodule // phy_port_link_control_bits_tb_top

bind phy_port_link_control_bits link_ctl_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .port1_an_fail_i(port1_an_fail_i),
  .port1_an_full_duplex_i(port1_an_full_duplex_i), .port1_mdix_status_i(port1_mdix_status_i),
  .port1_an_enable_o(port1_an_enable_o), .port1_full_duplex_o(port1_full_duplex_o),
  .port1_adv_o(port1_adv_o), .port1_indicator_pin_one_o(port1_indicator_pin_one_o),
  .port1_indicator_pin_zero_o(port1_indicator_pin_zero_o), .port1_tx_disable_o(port1_tx_disable_o),
  .port1_an_restart_o(port1_an_restart_o), .port1_auto_mdix_en_o(port1_auto_mdix_en_o),
  .port1_tx_on_receive_named_pair_o(port1_tx_on_receive_named_pair_o));
`default_nettype wire
